// ===== rtl/in_app_flash_update_ctrl.sv
// in-application flash update controller: registers, unlock, sequencer
// assumes a CPU register port, a flash engine with a req/done handshake
`timescale 1ns/100ps
`include "iap_ctrl_defines.svh"
module in_app_flash_update_ctrl (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic I_SFR_WE,
  input wire logic I_SFR_RE,
  output logic [7:0] O_SFR_RDATA,
  output logic O_CPU_HOLD,
  output logic O_FAST_OSC_EN,
  output logic O_FLASH_REQ,
  output logic [7:0] O_FLASH_CMD,
  output logic [15:0] O_FLASH_ADDR,
  output logic [7:0] O_FLASH_WDATA,
  input wire logic I_FLASH_DONE,
  input wire logic [7:0] I_FLASH_RDATA,
  input wire logic I_BOD_LOW,
  input wire logic I_BOD_EN,
  input wire logic I_BOR_EN
);
  import iap_ctrl_pkg::*;

  iap_ctrl_pkg::unlock_state_t unlock_state_reg;
  iap_ctrl_pkg::seq_state_t seq_reg;
  logic update_enable_reg;
  logic fault_flag_reg;
  logic [2:0] permit_reg;
  logic [7:0] command_reg;
  logic [7:0] addr_low_reg;
  logic [7:0] addr_high_reg;
  logic [7:0] data_reg;
  logic [7:0] bo_config_reg;
  logic [7:0] rdata_next;
  logic access;
  logic prot_wr;
  logic go_request;
  logic go_accepted;
  logic fault_set;
  logic op_done;
  logic [15:0] target_addr;

  iap_check_if chk_if ();

  // ----------------------------------------
  // fault checker
  // ----------------------------------------
  iap_fault_check u_check (
    .chk(chk_if.chk)
  );

  // checker sees the live registers at the moment of the trigger
  assign chk_if.cmd = command_reg;
  assign chk_if.addr = target_addr;
  assign chk_if.permit = permit_reg;
  assign chk_if.bo_inhibit = bo_config_reg[`BIT_BOD_INHIBIT];
  assign chk_if.bod_low = I_BOD_LOW;
  assign chk_if.bod_en = I_BOD_EN;
  assign chk_if.bor_en = I_BOR_EN;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // protected writes pass only while the unlock is open
  assign access = I_SFR_WE || I_SFR_RE;
  assign prot_wr = I_SFR_WE && unlock_state_reg == UNLOCK_OPEN &&
                   (I_SFR_ADDR == `ADDR_CHIP_CONTROL || I_SFR_ADDR == `ADDR_REGION_PERMIT ||
                    I_SFR_ADDR == `ADDR_OP_TRIGGER);
  assign target_addr = {addr_high_reg, addr_low_reg};
  assign go_request = prot_wr && I_SFR_ADDR == `ADDR_OP_TRIGGER &&
                      I_SFR_WDATA[`BIT_OPERATION_GO] && seq_reg == SEQ_IDLE;
  assign go_accepted = go_request && update_enable_reg;
  assign fault_set = go_accepted && chk_if.fault;
  assign op_done = seq_reg == SEQ_RUN && I_FLASH_DONE;

  // ----------------------------------------
  // timed-access unlock
  // ----------------------------------------
  // two keys on back-to-back accesses open one protected write
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      unlock_state_reg <= UNLOCK_IDLE;
    end else if (access) begin
      unique case (unlock_state_reg)
        UNLOCK_IDLE: begin
          if (I_SFR_WE && I_SFR_ADDR == `ADDR_TIMED_ACCESS &&
              I_SFR_WDATA == `UNLOCK_KEY_FIRST) begin
            unlock_state_reg <= UNLOCK_HALF;
          end
        end
        UNLOCK_HALF: begin
          if (I_SFR_WE && I_SFR_ADDR == `ADDR_TIMED_ACCESS &&
              I_SFR_WDATA == `UNLOCK_KEY_SECOND) begin
            unlock_state_reg <= UNLOCK_OPEN;
          end else begin
            unlock_state_reg <= UNLOCK_IDLE;
          end
        end
        UNLOCK_OPEN: unlock_state_reg <= UNLOCK_IDLE;
        default: unlock_state_reg <= UNLOCK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // chip control
  // ----------------------------------------
  // enable bit and oscillator request
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      update_enable_reg <= 1'b0;
    end else if (prot_wr && I_SFR_ADDR == `ADDR_CHIP_CONTROL) begin
      update_enable_reg <= I_SFR_WDATA[`BIT_UPDATE_ENABLE];
    end
  end

  assign O_FAST_OSC_EN = update_enable_reg;

  // fault flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      fault_flag_reg <= 1'b0;
    end else if (fault_set) begin
      fault_flag_reg <= 1'b1;
    end else if (prot_wr && I_SFR_ADDR == `ADDR_CHIP_CONTROL) begin
      fault_flag_reg <= I_SFR_WDATA[`BIT_FAULT_FLAG];
    end
  end

  // ----------------------------------------
  // permits, command, address
  // ----------------------------------------
  // region permit bits, protected
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      permit_reg <= `PERMIT_ZERO;
    end else if (prot_wr && I_SFR_ADDR == `ADDR_REGION_PERMIT) begin
      permit_reg <= I_SFR_WDATA[`PERMIT_MSB:0];
    end
  end

  // command byte: block, erase-program, aux, operation code
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      command_reg <= `RST_FLASH_COMMAND;
    end else if (I_SFR_WE && I_SFR_ADDR == `ADDR_FLASH_COMMAND) begin
      command_reg <= I_SFR_WDATA;
    end
  end

  // target address bytes
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      addr_low_reg <= `BYTE_ZERO;
      addr_high_reg <= `BYTE_ZERO;
    end else if (I_SFR_WE) begin
      if (I_SFR_ADDR == `ADDR_TARGET_LOW) begin
        addr_low_reg <= I_SFR_WDATA;
      end
      if (I_SFR_ADDR == `ADDR_TARGET_HIGH) begin
        addr_high_reg <= I_SFR_WDATA;
      end
    end
  end

  // data byte: software load, or fetched byte at end of a read
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      data_reg <= `BYTE_ZERO;
    end else if (op_done && !O_FLASH_CMD[`CMD_ERASE_PROGRAM]) begin
      data_reg <= I_FLASH_RDATA;
    end else if (I_SFR_WE && I_SFR_ADDR == `ADDR_FLASH_DATA) begin
      data_reg <= I_SFR_WDATA;
    end
  end

  // ----------------------------------------
  // brown-out config byte
  // ----------------------------------------
  // local copy of the config byte; programming only clears bits
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bo_config_reg <= `RST_BROWNOUT_CONFIG;
    end else if (op_done && cmd_is_update(O_FLASH_CMD) &&
                 O_FLASH_CMD[`CMD_BLOCK_MSB:`CMD_BLOCK_LSB] == `BLK_CONFIG) begin
      if (O_FLASH_CMD[`CMD_OP_MSB:0] == `OPC_ERASE) begin
        bo_config_reg <= `BYTE_ONES;
      end else if (O_FLASH_ADDR == `CFG_BROWNOUT_ADDR) begin
        bo_config_reg <= bo_config_reg & O_FLASH_WDATA;
      end
    end
  end

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  // a faulting trigger never leaves idle, so the CPU is not held
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      unique case (seq_reg)
        SEQ_IDLE: begin
          if (go_accepted && !chk_if.fault) begin
            seq_reg <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (I_FLASH_DONE) begin
            seq_reg <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // operation copy handed to the flash engine at the trigger
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_FLASH_CMD <= `RST_FLASH_COMMAND;
      O_FLASH_ADDR <= `ADDR_NONE;
      O_FLASH_WDATA <= `BYTE_ZERO;
    end else if (go_accepted && !chk_if.fault) begin
      O_FLASH_CMD <= command_reg;
      O_FLASH_WDATA <= data_reg;
      if (cmd_is_update(command_reg) && command_reg[`CMD_OP_MSB:0] == `OPC_ERASE) begin
        O_FLASH_ADDR <= target_addr & `PAGE_MASK;
      end else begin
        O_FLASH_ADDR <= target_addr;
      end
    end
  end

  assign O_FLASH_REQ = seq_reg == SEQ_RUN;
  assign O_CPU_HOLD = seq_reg == SEQ_RUN;

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // read data registered one cycle after the read strobe
  always_comb begin
    rdata_next = `BYTE_ZERO;
    unique case (I_SFR_ADDR)
      `ADDR_CHIP_CONTROL: begin
        rdata_next[`BIT_FAULT_FLAG] = fault_flag_reg;
        rdata_next[`BIT_UPDATE_ENABLE] = update_enable_reg;
      end
      `ADDR_REGION_PERMIT: rdata_next[`PERMIT_MSB:0] = permit_reg;
      `ADDR_TARGET_LOW: rdata_next = addr_low_reg;
      `ADDR_TARGET_HIGH: rdata_next = addr_high_reg;
      `ADDR_FLASH_DATA: rdata_next = data_reg;
      `ADDR_FLASH_COMMAND: rdata_next = command_reg;
      default: rdata_next = `BYTE_ZERO; // trigger reads zero
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_SFR_RDATA <= `BYTE_ZERO;
    end else if (I_SFR_RE) begin
      O_SFR_RDATA <= rdata_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_fault_sets_flag: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    go_accepted && chk_if.fault |=> fault_flag_reg)
    else $error("fault on trigger did not set flag");
  a_fault_no_run: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    go_accepted && chk_if.fault |=> !O_CPU_HOLD && !O_FLASH_REQ)
    else $error("faulting operation reached flash");
  a_go_holds_cpu: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    go_accepted && !chk_if.fault |=> O_CPU_HOLD && O_FLASH_REQ && O_FLASH_CMD == $past(command_reg))
    else $error("trigger did not start operation");
  a_done_release: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    O_FLASH_REQ && I_FLASH_DONE |=> !O_CPU_HOLD)
    else $error("cpu still held after completion");
  a_flag_sticky: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    fault_flag_reg && !(prot_wr && I_SFR_ADDR == `ADDR_CHIP_CONTROL) |=> fault_flag_reg)
    else $error("fault flag cleared without software");
  a_unlock_single: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    prot_wr |=> unlock_state_reg == UNLOCK_IDLE)
    else $error("unlock survived a protected write");
  a_locked_ignored: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    I_SFR_WE && I_SFR_ADDR == `ADDR_REGION_PERMIT && unlock_state_reg != UNLOCK_OPEN
    |=> permit_reg == $past(permit_reg))
    else $error("locked permit register changed");
  a_disabled_idle: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    go_request && !update_enable_reg |=> !O_CPU_HOLD)
    else $error("trigger accepted while disabled");
  a_read_capture: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    op_done && !O_FLASH_CMD[`CMD_ERASE_PROGRAM] |=> data_reg == $past(I_FLASH_RDATA))
    else $error("read byte not captured");
  a_trigger_zero: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    I_SFR_RE && I_SFR_ADDR == `ADDR_OP_TRIGGER |=> O_SFR_RDATA == `BYTE_ZERO)
    else $error("trigger register read nonzero");
  a_page_aligned: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    O_FLASH_REQ && cmd_is_update(O_FLASH_CMD) && O_FLASH_CMD[`CMD_OP_MSB:0] == `OPC_ERASE
    |-> O_FLASH_ADDR[6:0] == `PAGE_OFFSET_ZERO)
    else $error("page erase address not aligned");
endmodule

// ===== rtl/iap_ctrl_defines.svh
// constants of the flash update controller: addresses, fields, codes
// assumes an 8-bit special-function-register space
`ifndef IAP_CTRL_DEFINES_SVH
`define IAP_CTRL_DEFINES_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_CHIP_CONTROL 8'h9f
`define ADDR_OP_TRIGGER 8'ha4
`define ADDR_REGION_PERMIT 8'ha5
`define ADDR_TARGET_LOW 8'ha6
`define ADDR_TARGET_HIGH 8'ha7
`define ADDR_FLASH_DATA 8'hae
`define ADDR_FLASH_COMMAND 8'haf
`define ADDR_TIMED_ACCESS 8'hb7

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define RST_FLASH_COMMAND 8'h30
`define RST_BROWNOUT_CONFIG 8'hff
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff
`define PERMIT_ZERO 3'h0
`define UNLOCK_KEY_FIRST 8'haa
`define UNLOCK_KEY_SECOND 8'h55

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_UPDATE_ENABLE 0
`define BIT_FAULT_FLAG 6
`define BIT_OPERATION_GO 0
`define BIT_PERMIT_CONFIG 2
`define BIT_PERMIT_LOADER 1
`define BIT_PERMIT_APP 0
`define PERMIT_MSB 2
`define BIT_BOD_INHIBIT 3
`define CMD_BLOCK_MSB 7
`define CMD_BLOCK_LSB 6
`define CMD_ERASE_PROGRAM 5
`define CMD_AUX 4
`define CMD_OP_MSB 3

// ----------------------------------------
// command codes and limits
// ----------------------------------------
`define OPC_READ 4'h0
`define OPC_PROGRAM 4'h1
`define OPC_ERASE 4'h2
`define OPC_UNIQUE_READ 4'h4
`define OPC_MAKER_READ 4'hb
`define OPC_DEVICE_READ 4'hc
`define BLK_APP 2'h0
`define BLK_LOADER 2'h1
`define BLK_CONFIG 2'h3
`define LIMIT_APP 16'h3fff
`define LIMIT_LOADER 16'h0fff
`define LIMIT_CONFIG 16'h0004
`define LIMIT_UNIQUE 16'h000b
`define LIMIT_DEVICE 16'h0001
`define ADDR_NONE 16'h0000
`define PAGE_MASK 16'hff80
`define PAGE_OFFSET_ZERO 7'h00
`define CFG_BROWNOUT_ADDR 16'h0002

`endif

// ===== rtl/iap_ctrl_pkg.sv
// types and shared decoding of the flash update controller
// assumes the constants header is on the include path
package iap_ctrl_pkg;
  `include "iap_ctrl_defines.svh"

  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_HALF = 2'b01,
    UNLOCK_OPEN = 2'b11
  } unlock_state_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_state_t;

  // true for a well-formed erase or program command
  function automatic logic cmd_is_update(input logic [7:0] cmd);
    logic [3:0] opc;
    opc = cmd[`CMD_OP_MSB:0];
    return cmd[`CMD_ERASE_PROGRAM] && !cmd[`CMD_AUX] &&
           (opc == `OPC_PROGRAM || opc == `OPC_ERASE);
  endfunction
endpackage

// ===== rtl/iap_check_if.sv
// carrier between the sequencer and its fault checker
// assumes both sides sit in the same clock domain
`timescale 1ns/100ps
interface iap_check_if;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [2:0] permit;
  logic bo_inhibit;
  logic bod_low;
  logic bod_en;
  logic bor_en;
  logic fault;

  modport seq (output cmd, addr, permit, bo_inhibit, bod_low, bod_en, bor_en, input fault);
  modport chk (input cmd, addr, permit, bo_inhibit, bod_low, bod_en, bor_en, output fault);
endinterface

// ===== rtl/iap_fault_check.sv
// combinational fault check of a triggered flash operation
// assumes command, address and permits are stable while sampled
`timescale 1ns/100ps
`include "iap_ctrl_defines.svh"
module iap_fault_check (
  iap_check_if.chk chk
);
  import iap_ctrl_pkg::*;

  logic [1:0] blk;
  logic [3:0] opc;
  logic rd_ok;
  logic up_ok;
  logic addr_bad;
  logic perm_bad;
  logic bo_bad;
  logic [15:0] limit;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // legal reads and updates; block code 2 is legal only for the maker, device and unique reads
  always_comb begin
    blk = chk.cmd[`CMD_BLOCK_MSB:`CMD_BLOCK_LSB];
    opc = chk.cmd[`CMD_OP_MSB:0];
    rd_ok = !chk.cmd[`CMD_ERASE_PROGRAM] && !chk.cmd[`CMD_AUX] &&
            ((opc == `OPC_READ && blk != 2'h2) || opc == `OPC_MAKER_READ ||
             opc == `OPC_DEVICE_READ || opc == `OPC_UNIQUE_READ);
    up_ok = cmd_is_update(chk.cmd) && blk != 2'h2;
  end

  // ----------------------------------------
  // address range
  // ----------------------------------------
  // upper limit per command kind; whole config erase needs address zero
  always_comb begin
    limit = `LIMIT_APP;
    if (rd_ok && opc == `OPC_DEVICE_READ) begin
      limit = `LIMIT_DEVICE;
    end else if (rd_ok && opc == `OPC_UNIQUE_READ) begin
      limit = `LIMIT_UNIQUE;
    end else if (blk == `BLK_LOADER) begin
      limit = `LIMIT_LOADER;
    end else if (blk == `BLK_CONFIG) begin
      limit = `LIMIT_CONFIG;
    end
    if (rd_ok && opc == `OPC_MAKER_READ) begin
      addr_bad = 1'b0;
    end else if (up_ok && blk == `BLK_CONFIG && opc == `OPC_ERASE) begin
      addr_bad = chk.addr != `ADDR_NONE;
    end else begin
      addr_bad = chk.addr > limit;
    end
  end

  // ----------------------------------------
  // permits and brown-out
  // ----------------------------------------
  // per-region permit bits and the brown-out inhibit of updates
  always_comb begin
    unique case (blk)
      `BLK_APP: perm_bad = !chk.permit[`BIT_PERMIT_APP];
      `BLK_LOADER: perm_bad = !chk.permit[`BIT_PERMIT_LOADER];
      `BLK_CONFIG: perm_bad = !chk.permit[`BIT_PERMIT_CONFIG];
      default: perm_bad = 1'b1;
    endcase
    perm_bad = perm_bad && up_ok;
    bo_bad = up_ok && chk.bo_inhibit && chk.bod_en && !chk.bor_en && chk.bod_low;
  end

  assign chk.fault = !(rd_ok || up_ok) || addr_bad || perm_bad || bo_bad;
endmodule

// ===== bench/flash_array_model.sv
// behavioural flash array with a req/done engine facing the update controller
// assumes req and its command, address and data stay put until done is seen
`timescale 1ns/100ps
module flash_array_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [7:0] i_cmd,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_delay,
  output logic o_done,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [int];
  logic [7:0] cnt;
  int key;
  // ----------------------------------------
  // engine: waits i_delay cycles, then one done pulse
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      cnt <= 8'h00;
      o_rdata <= 8'h00;
    end else if (i_req && !o_done && cnt == i_delay) begin
      cnt <= 8'h00;
      o_done <= 1'b1;
      key = int'({i_cmd[7:6], i_addr});
      if (i_cmd[5] && i_cmd[3:0] == 4'h2) begin
        for (int i = 0; i < 128; i++) begin
          mem.delete((key & ~127) + i); // erased bytes read as all ones
        end
      end else if (i_cmd[5] && i_cmd[3:0] == 4'h1) begin
        mem[key] = (mem.exists(key) ? mem[key] : 8'hff) & i_wdata; // only clears bits
      end
      o_rdata <= (i_cmd[3:0] != 4'h0) ? 8'h3c : (mem.exists(key) ? mem[key] : 8'hff);
    end else begin
      o_done <= 1'b0;
      cnt <= (i_req && !o_done) ? cnt + 8'h01 : 8'h00;
      o_rdata <= ~o_rdata; // data churns outside the completion pulse
    end
  end
endmodule

// ===== bench/test_in_app_flash_update_ctrl.sv
// self-checking bench of the flash update controller
// assumes the constants header on the include path and the array model beside it
`timescale 1ns/100ps
`include "iap_ctrl_defines.svh"
module test_in_app_flash_update_ctrl;
  logic clk, rst, sfr_we, sfr_re, cpu_hold, osc_en, flash_req, flash_done;
  logic bod_low, bod_en, bor_en;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_cmd, flash_wdata, flash_rdata, delay, v;
  logic [15:0] flash_addr, a;
  logic [7:0] exp_mem [int];
  logic [7:0] ra [8] = '{`ADDR_CHIP_CONTROL, `ADDR_REGION_PERMIT, `ADDR_TARGET_LOW,
    `ADDR_TARGET_HIGH, `ADDR_FLASH_DATA, `ADDR_FLASH_COMMAND, `ADDR_OP_TRIGGER, 8'h80};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00};
  logic [7:0] fc [5] = '{8'h23, 8'h31, 8'h61, 8'he1, 8'ha1};
  int failures, cmp_count, seed, r;

  in_app_flash_update_ctrl i_in_app_flash_update_ctrl (.I_MCLK(clk), .I_SYS_RST(rst),
    .I_SFR_ADDR(sfr_addr), .I_SFR_WDATA(sfr_wdata), .I_SFR_WE(sfr_we), .I_SFR_RE(sfr_re),
    .O_SFR_RDATA(sfr_rdata), .O_CPU_HOLD(cpu_hold), .O_FAST_OSC_EN(osc_en),
    .O_FLASH_REQ(flash_req), .O_FLASH_CMD(flash_cmd), .O_FLASH_ADDR(flash_addr),
    .O_FLASH_WDATA(flash_wdata), .I_FLASH_DONE(flash_done), .I_FLASH_RDATA(flash_rdata),
    .I_BOD_LOW(bod_low), .I_BOD_EN(bod_en), .I_BOR_EN(bor_en));
  flash_array_model i_flash_array_model (.i_clk(clk), .i_rst(rst), .i_req(flash_req),
    .i_cmd(flash_cmd), .i_addr(flash_addr), .i_wdata(flash_wdata), .i_delay(delay),
    .o_done(flash_done), .o_rdata(flash_rdata));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // ----------------------------------------
  // register port: one access per cycle, driven at the rising edge
  // ----------------------------------------
  task automatic access(input logic w, input logic rd, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfr_we <= w;
    sfr_re <= rd;
    sfr_addr <= ad;
    sfr_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    access(1'b1, 1'b0, ad, d);
  endtask
  task automatic pwr(input logic [7:0] ad, input logic [7:0] d);
    wr(`ADDR_TIMED_ACCESS, `UNLOCK_KEY_FIRST);
    wr(`ADDR_TIMED_ACCESS, `UNLOCK_KEY_SECOND);
    wr(ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    access(1'b0, 1'b1, ad, 8'h00);
    access(1'b0, 1'b0, ad, 8'h00);
    #1 d = sfr_rdata;
  endtask
  task automatic set_bod(input logic l, input logic e, input logic b);
    @(posedge clk);
    bod_low <= l;
    bod_en <= e;
    bor_en <= b;
  endtask

  // expected array content after an operation, and the byte a read returns
  function automatic logic [7:0] model_op(input logic [7:0] c, input logic [15:0] ad,
                                          input logic [7:0] d);
    int k;
    k = int'({c[7:6], ad});
    if (c[3:0] == `OPC_ERASE) begin
      for (int i = 0; i < 128; i++) begin
        exp_mem.delete((k & ~127) + i);
      end
    end else if (c[3:0] == `OPC_PROGRAM) begin
      exp_mem[k] = (exp_mem.exists(k) ? exp_mem[k] : 8'hff) & d;
    end
    return exp_mem.exists(k) ? exp_mem[k] : 8'hff;
  endfunction

  // one triggered operation, checked at the flash side and the registers
  task automatic run(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] d,
                     input logic f);
    logic [7:0] e;
    logic [7:0] g;
    int n;
    wr(`ADDR_FLASH_COMMAND, c);
    wr(`ADDR_TARGET_HIGH, ad[15:8]);
    wr(`ADDR_TARGET_LOW, ad[7:0]);
    wr(`ADDR_FLASH_DATA, d);
    pwr(`ADDR_OP_TRIGGER, 8'h01);
    access(1'b0, 1'b0, 8'h00, 8'h00);
    n = 0;
    #1;
    while (cpu_hold !== 1'b1 && n < 3) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cpu_hold", {15'h0, ~f}, {15'h0, cpu_hold});
    chk("flash_req", {15'h0, ~f}, {15'h0, flash_req});
    if (!f) begin
      chk("flash_cmd", {8'h00, c}, {8'h00, flash_cmd});
      chk("flash_addr", (c[3:0] == `OPC_ERASE) ? ad & 16'hff80 : ad, flash_addr);
      chk("flash_wdata", {8'h00, d}, {8'h00, flash_wdata});
      e = model_op(c, ad, d);
      n = 0;
      while (cpu_hold === 1'b1 && n < 300) begin
        @(posedge clk);
        #1 n++;
      end
      if (n == 300) begin
        failures++;
        conclude();
      end
      if (!c[5]) begin
        rd(`ADDR_FLASH_DATA, g);
        chk("read_byte", {8'h00, (c[3:0] == `OPC_READ) ? e : 8'h3c}, {8'h00, g});
      end
    end
    rd(`ADDR_CHIP_CONTROL, g);
    chk("chip_control", {8'h00, 1'b0, f, 6'h01}, {8'h00, g & 8'h41});
    if (f) begin
      rd(`ADDR_CHIP_CONTROL, g);
      chk("flag_sticky", 16'h0041, {8'h00, g});
      pwr(`ADDR_CHIP_CONTROL, 8'h01);
      rd(`ADDR_CHIP_CONTROL, g);
      chk("flag_clear", 16'h0001, {8'h00, g});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'ha488;
    failures = 0;
    cmp_count = 0;
    {sfr_we, sfr_re, bod_low, bod_en, bor_en} = 5'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    delay = 8'h00;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], v);
      chk("reset_value", {8'h00, rv[i]}, {8'h00, v});
    end
    chk("osc_off", 16'h0, {15'h0, osc_en});
    pwr(`ADDR_OP_TRIGGER, 8'h01); // trigger while disabled is dropped
    repeat (3) access(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("hold_disabled", 16'h0, {15'h0, cpu_hold});
    wr(`ADDR_REGION_PERMIT, 8'h07);
    rd(`ADDR_REGION_PERMIT, v);
    chk("permit_nokey", 16'h0, {8'h00, v});
    wr(`ADDR_TIMED_ACCESS, `UNLOCK_KEY_FIRST);
    rd(`ADDR_TARGET_LOW, v);
    wr(`ADDR_TIMED_ACCESS, `UNLOCK_KEY_SECOND);
    wr(`ADDR_REGION_PERMIT, 8'h07);
    rd(`ADDR_REGION_PERMIT, v);
    chk("permit_broken_key", 16'h0, {8'h00, v});
    pwr(`ADDR_REGION_PERMIT, 8'h01);
    wr(`ADDR_REGION_PERMIT, 8'h07);
    rd(`ADDR_REGION_PERMIT, v);
    chk("permit_relock", 16'h0001, {8'h00, v});
    pwr(`ADDR_CHIP_CONTROL, 8'h01);
    access(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("osc_on", 16'h1, {15'h0, osc_en});
    run(8'h21, 16'h3fff, 8'ha5, 1'b0);
    run(8'h21, 16'h4000, 8'ha5, 1'b1);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      delay <= r[31] ? 8'h28 : {5'h0, r[18:16]};
      set_bod(r[24], 1'b0, r[25]);
      a = 16'h0200 + {8'h00, r[7:0]};
      run((r[1:0] == 2'h0) ? 8'h00 : {6'h08, r[1:0] == 2'h1 ? 2'h1 : 2'h2}, a, r[15:8], 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      run(fc[i], 16'h0002, 8'h00, 1'b1);
    end
    pwr(`ADDR_REGION_PERMIT, 8'h07);
    run(8'h61, 16'h0fff, 8'h3c, 1'b0);
    run(8'h40, 16'h0fff, 8'h00, 1'b0);
    run(8'h61, 16'h1000, 8'h00, 1'b1);
    set_bod(1'b1, 1'b1, 1'b0);
    run(8'h21, 16'h0300, 8'h00, 1'b1);
    run(8'h00, 16'h0300, 8'h00, 1'b0);
    set_bod(1'b1, 1'b1, 1'b1);
    run(8'h21, 16'h0300, 8'h0f, 1'b0);
    set_bod(1'b0, 1'b1, 1'b0);
    run(8'he1, 16'h0002, 8'hf7, 1'b0);
    set_bod(1'b1, 1'b1, 1'b0);
    run(8'h21, 16'h0301, 8'h5a, 1'b0);
    run(8'h0b, 16'hffff, 8'h00, 1'b0);
    run(8'h0c, 16'h0002, 8'h00, 1'b1);
    run(8'h04, 16'h000b, 8'h00, 1'b0);
    run(8'he2, 16'h0001, 8'h00, 1'b1);
    run(8'he2, 16'h0000, 8'h00, 1'b0);
    run(8'h21, 16'h0302, 8'h00, 1'b1);
    pwr(`ADDR_CHIP_CONTROL, 8'h00);
    access(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("osc_stop", 16'h0, {15'h0, osc_en});
    conclude();
  end
endmodule
